// [design/wmt_defs.svh]
// Constants for the channel 5..7 window-monitor threshold register bank
// Operation
// - Upper high-limit byte compares with result bits 11:4.
// - High-limit low nibble sits in margin register bits 7:4, compares with bits 3:0.
// - Low-limit low nibble sits in persistence register bits 7:4, compares with bits 3:0.
// - Upper low-limit byte plus its nibble form the 12-bit low limit.
// - Alert flag sets only after n+1 consecutive out-of-window samples.
// - 4-bit margin shifted left three acts on both limits as 7-bit hysteresis.
// - Reset sets upper high-limit bytes and high-limit nibbles to all ones.
// - Reset clears low-limit bytes, low-limit nibbles and persistence counts.
// - Reset loads each margin register with 0xF0.
// - Per channel: margin, high limit, persistence, low limit at consecutive addresses.
// - All fields read back the last value the host wrote.
`ifndef WMT_DEFS_SVH
`define WMT_DEFS_SVH

// Register addresses
`define WMT_CH5_MARGIN_AND_HIGH_NIBBLE  8'h34
`define WMT_CH5_HIGH_LIMIT_UPPER        8'h35
`define WMT_CH5_PERSIST_AND_LOW_NIBBLE  8'h36
`define WMT_CH5_LOW_LIMIT_UPPER         8'h37
`define WMT_CH6_MARGIN_AND_HIGH_NIBBLE  8'h38
`define WMT_CH6_HIGH_LIMIT_UPPER        8'h39
`define WMT_CH6_PERSIST_AND_LOW_NIBBLE  8'h3A
`define WMT_CH6_LOW_LIMIT_UPPER         8'h3B
`define WMT_CH7_MARGIN_AND_HIGH_NIBBLE  8'h3C
`define WMT_CH7_HIGH_LIMIT_UPPER        8'h3D
`define WMT_CH7_PERSIST_AND_LOW_NIBBLE  8'h3E
`define WMT_CH7_LOW_LIMIT_UPPER         8'h3F

// Slot of each register inside a channel group
`define WMT_SLOT_MARGIN   2'h0
`define WMT_SLOT_HIGH     2'h1
`define WMT_SLOT_PERSIST  2'h2
`define WMT_SLOT_LOW      2'h3

// Reset values
`define WMT_RST_MARGIN   8'hF0
`define WMT_RST_HIGH     8'hFF
`define WMT_RST_PERSIST  8'h00
`define WMT_RST_LOW      8'h00

// Field positions
`define WMT_NIB_MSB   7
`define WMT_NIB_LSB   4
`define WMT_CFG_MSB   3
`define WMT_CFG_LSB   0
`define WMT_HYST_SHIFT 3

// Persistence counter ceiling, one above the largest count setting
`define WMT_CNT_MAX   5'h10

// First converter channel served by this bank
`define WMT_FIRST_CH  3'h5

`endif

// [design/wmt_pkg.sv]
// Types shared by the window-monitor threshold bank
`default_nettype none
package wmt_pkg;
   typedef logic [7:0]  wmt_byte_t;
   typedef logic [11:0] wmt_code_t;
   typedef logic [3:0]  wmt_nib_t;
   typedef logic [3:0]  wmt_idx_t;
   typedef logic [4:0]  wmt_cnt_t;

   typedef enum logic [1:0] {
      WMT_IN    = 2'b00,
      WMT_OVER  = 2'b01,
      WMT_UNDER = 2'b10
   } wmt_win_e;
endpackage : wmt_pkg
`default_nettype wire

// [design/wmt_win_chk.sv]
// Per-channel window comparator with hysteresis and persistence counter
`timescale 1ns/10ps
`default_nettype none
`include "wmt_defs.svh"

module wmt_win_chk (
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               sample_valid,
   input  wire wmt_pkg::wmt_code_t sample_code,
   input  wire wmt_pkg::wmt_byte_t high_top,
   input  wire wmt_pkg::wmt_nib_t  high_nib,
   input  wire wmt_pkg::wmt_byte_t low_top,
   input  wire wmt_pkg::wmt_nib_t  low_nib,
   input  wire wmt_pkg::wmt_nib_t  margin,
   input  wire wmt_pkg::wmt_nib_t  persist,
   output logic                    alert_set
);

   wmt_pkg::wmt_code_t high_lim;
   wmt_pkg::wmt_code_t low_lim;
   wmt_pkg::wmt_code_t hyst;
   wmt_pkg::wmt_code_t high_rel;
   logic [12:0]        low_sum;
   wmt_pkg::wmt_code_t low_rel;
   wmt_pkg::wmt_win_e  state_reg;
   wmt_pkg::wmt_win_e  state_next;
   wmt_pkg::wmt_cnt_t  cnt_reg;
   wmt_pkg::wmt_cnt_t  cnt_next;
   wmt_pkg::wmt_cnt_t  cnt_plus;

   ////////////////////////////////////////////////////////////////////////////////
   // Limits
   always_comb begin
      high_lim = {high_top, high_nib};
      low_lim  = {low_top, low_nib};
      hyst     = 12'({margin, 3'h0});
      // Saturate so a wide margin cannot wrap the release point round
      high_rel = (high_lim > hyst) ? (high_lim - hyst) : 12'h000;
      low_sum  = {1'b0, low_lim} + {1'b0, hyst};
      low_rel  = low_sum[12] ? 12'hFFF : low_sum[11:0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Window state and persistence count
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      // Saturate so a long excursion can never wrap back below the setting
      cnt_plus   = (cnt_reg == `WMT_CNT_MAX) ? cnt_reg : cnt_reg + 5'h01;
      alert_set  = 1'b0;
      if (sample_valid) begin
         unique case (state_reg)
            wmt_pkg::WMT_IN: begin
               if (sample_code > high_lim) begin
                  state_next = wmt_pkg::WMT_OVER;
               end else if (sample_code < low_lim) begin
                  state_next = wmt_pkg::WMT_UNDER;
               end
            end
            wmt_pkg::WMT_OVER: begin
               if (sample_code < low_lim) begin
                  state_next = wmt_pkg::WMT_UNDER;
               end else if (sample_code <= high_rel) begin
                  state_next = wmt_pkg::WMT_IN;
               end
            end
            wmt_pkg::WMT_UNDER: begin
               if (sample_code > high_lim) begin
                  state_next = wmt_pkg::WMT_OVER;
               end else if (sample_code >= low_rel) begin
                  state_next = wmt_pkg::WMT_IN;
               end
            end
            default: begin
               state_next = wmt_pkg::WMT_IN;
            end
         endcase
         if (state_next == wmt_pkg::WMT_IN) begin
            cnt_next = 5'h00;
         end else begin
            cnt_next  = cnt_plus;
            alert_set = (cnt_plus >= ({1'b0, persist} + 5'h01));
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= wmt_pkg::WMT_IN;
         cnt_reg   <= 5'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

endmodule : wmt_win_chk
`default_nettype wire

// [design/wmt_threshold_regs.sv]
// Window-monitor threshold register bank for converter channels 5 to 7
`timescale 1ns/10ps
`default_nettype none
`include "wmt_defs.svh"

module wmt_threshold_regs (
   input  wire logic               CLK,
   input  wire logic               RST_B,
   input  wire logic [7:0]         REG_ADDR,
   input  wire wmt_pkg::wmt_byte_t REG_WDATA,
   input  wire logic               REG_WR,
   input  wire logic               REG_RD,
   output wmt_pkg::wmt_byte_t      REG_RDATA,
   output logic                    REG_HIT,
   input  wire logic               SAMPLE_VALID,
   input  wire logic [2:0]         SAMPLE_CH,
   input  wire wmt_pkg::wmt_code_t SAMPLE_DATA,
   input  wire logic [2:0]         ALERT_CLR,
   output logic [2:0]              ALERT
);

   localparam int NUM_REGS = 12;
   localparam int NUM_CH   = 3;

   wmt_pkg::wmt_byte_t mem_reg  [NUM_REGS];
   wmt_pkg::wmt_byte_t mem_next [NUM_REGS];
   logic               in_range;
   logic [7:0]         addr_ofs;
   wmt_pkg::wmt_idx_t  idx;
   wmt_pkg::wmt_byte_t rdata_reg;
   wmt_pkg::wmt_byte_t rdata_next;
   logic               hit_reg;
   logic               hit_next;
   logic [2:0]         alert_reg;
   logic [2:0]         alert_next;
   logic [2:0]         alert_set;
   logic [2:0]         ch_valid;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode
   always_comb begin
      in_range = (REG_ADDR >= `WMT_CH5_MARGIN_AND_HIGH_NIBBLE) &&
                 (REG_ADDR <= `WMT_CH7_LOW_LIMIT_UPPER);
      addr_ofs = REG_ADDR - `WMT_CH5_MARGIN_AND_HIGH_NIBBLE;
      idx      = addr_ofs[3:0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register storage
   always_comb begin
      for (int i = 0; i < NUM_REGS; i++) begin
         mem_next[i] = mem_reg[i];
      end
      if (REG_WR && in_range) begin
         mem_next[idx] = REG_WDATA;
      end
   end

   for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
      // Reset value chosen by the slot inside the channel group
      localparam wmt_pkg::wmt_byte_t RST_VAL =
         (r % 4 == 0) ? `WMT_RST_MARGIN :
         (r % 4 == 1) ? `WMT_RST_HIGH   :
         (r % 4 == 2) ? `WMT_RST_PERSIST : `WMT_RST_LOW;
      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            mem_reg[r] <= RST_VAL;
         end else begin
            mem_reg[r] <= mem_next[r];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read port: data one cycle after the strobe, zero outside the bank
   always_comb begin
      rdata_next = rdata_reg;
      hit_next   = 1'b0;
      if (REG_RD) begin
         hit_next   = in_range;
         rdata_next = in_range ? mem_reg[idx] : 8'h00;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rdata_reg <= 8'h00;
         hit_reg   <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         hit_reg   <= hit_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-channel comparators
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      always_comb begin
         ch_valid[c] = SAMPLE_VALID && (SAMPLE_CH == (`WMT_FIRST_CH + 3'(c)));
      end
      wmt_win_chk u_chk (
         .clk          (CLK),
         .rst_b        (RST_B),
         .sample_valid (ch_valid[c]),
         .sample_code  (SAMPLE_DATA),
         .high_top     (mem_reg[4*c + `WMT_SLOT_HIGH]),
         .high_nib     (mem_reg[4*c + `WMT_SLOT_MARGIN][`WMT_NIB_MSB:`WMT_NIB_LSB]),
         .low_top      (mem_reg[4*c + `WMT_SLOT_LOW]),
         .low_nib      (mem_reg[4*c + `WMT_SLOT_PERSIST][`WMT_NIB_MSB:`WMT_NIB_LSB]),
         .margin       (mem_reg[4*c + `WMT_SLOT_MARGIN][`WMT_CFG_MSB:`WMT_CFG_LSB]),
         .persist      (mem_reg[4*c + `WMT_SLOT_PERSIST][`WMT_CFG_MSB:`WMT_CFG_LSB]),
         .alert_set    (alert_set[c])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alert flags: a new event wins over a clear in the same cycle
   always_comb begin
      alert_next = (alert_reg & ~ALERT_CLR) | alert_set;
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         alert_reg <= 3'h0;
      end else begin
         alert_reg <= alert_next;
      end
   end

   assign REG_RDATA = rdata_reg;
   assign REG_HIT   = hit_reg;
   assign ALERT     = alert_reg;

endmodule : wmt_threshold_regs
`default_nettype wire

// [dv/wmt_threshold_regs_assertions.sv]
// Port-level checker for the threshold register bank
`timescale 1ns/10ps
`default_nettype none
module wmt_regs_checker (
   input wire logic               CLK,
   input wire logic               RST_B,
   input wire logic [7:0]         REG_ADDR,
   input wire wmt_pkg::wmt_byte_t REG_WDATA,
   input wire logic               REG_WR,
   input wire logic               REG_RD,
   input wire wmt_pkg::wmt_byte_t REG_RDATA,
   input wire logic               REG_HIT,
   input wire logic               SAMPLE_VALID,
   input wire logic [2:0]         SAMPLE_CH,
   input wire logic [2:0]         ALERT_CLR,
   input wire logic [2:0]         ALERT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   wire inr = REG_ADDR >= 8'h34 && REG_ADDR <= 8'h3F;
   a_hit_range : assert property (REG_RD && inr |=> REG_HIT)
      else $error("mapped read gave no hit");
   a_miss_zero : assert property (REG_RD && !inr |=> !REG_HIT && REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   a_hit_pulse : assert property (!REG_RD |=> !REG_HIT)
      else $error("hit without read");
   a_rdata_hold : assert property (!REG_RD |=> $stable(REG_RDATA))
      else $error("read data moved without read");
   a_readback_next : assert property (REG_WR && inr ##1 REG_RD && !REG_WR
      && REG_ADDR == $past(REG_ADDR) |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("read after write stale");
   a_alert_sticky : assert property ((($past(ALERT) & ~$past(ALERT_CLR)) & ~ALERT) == 3'h0)
      else $error("alert dropped without clear");
   a_alert_cause : assert property ((ALERT & ~$past(ALERT)) != 3'h0 |-> $past(SAMPLE_VALID)
      && (ALERT & ~$past(ALERT)) == 3'h1 << ($past(SAMPLE_CH) - 3'h5))
      else $error("alert rose without own sample");
   a_clear_works : assert property (ALERT_CLR != 3'h0 && !SAMPLE_VALID
      |=> (ALERT & $past(ALERT_CLR)) == 3'h0)
      else $error("alert clear ignored");
   c_alert : cover property ($rose(|ALERT));
   c_readback : cover property (REG_WR && inr ##1 REG_RD);
   c_miss : cover property (REG_RD && !inr);
   c_set_clear : cover property (SAMPLE_VALID && ALERT_CLR != 3'h0 ##1 ALERT != 3'h0);
endmodule : wmt_regs_checker
bind wmt_threshold_regs wmt_regs_checker chk (.*);
`default_nettype wire

// [dv/wmt_host_model.sv]
// Host model issuing byte reads and writes to the bank
`timescale 1ns/10ps
`default_nettype none
module wmt_host_model (
   input  wire logic               clk,
   output wmt_pkg::wmt_byte_t      addr = 8'h00,
   output wmt_pkg::wmt_byte_t      wdata = 8'h00,
   output logic                    wr = 1'b0,
   output logic                    rd = 1'b0,
   input  wire wmt_pkg::wmt_byte_t rdata,
   input  wire logic               hit
);
   // With w and r both set the read lands the cycle after the write
   task automatic xfer(input logic [7:0] a, d, input bit w, r, output logic [7:0] q,
                       output logic h);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = w;
      rd = r && !w;
      if (w) begin
         @(negedge clk);
         wr = 1'b0;
         rd = r;
      end
      @(negedge clk);
      q = rdata;
      h = hit;
      rd = 1'b0;
      // Idle lines show inverted values so stale data never looks valid
      addr = ~a;
      wdata = ~d;
   endtask : xfer
endmodule : wmt_host_model
`default_nettype wire

// [dv/window_monitor_threshold_regs_bench.sv]
// Self-checking bench for the channel 5..7 threshold bank
`timescale 1ns/10ps
`default_nettype none
module window_monitor_threshold_regs_bench;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        svalid = 1'b0;
   logic [2:0]  sch = 3'h0;
   logic [11:0] sdata = 12'h000;
   logic [2:0]  aclr = 3'h0;
   logic [2:0]  alert;
   logic [7:0]  addr, wdata, rdata, q, rm [12];
   logic        wr, rd, hit, h;
   int          st [3], cnt [3], exp_a, v, r, seed = 63, n_mismatch, checked, cyc;
   always #25 clk = ~clk;
   wmt_threshold_regs DUT (.CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_HIT(hit), .SAMPLE_VALID(svalid),
      .SAMPLE_CH(sch), .SAMPLE_DATA(sdata), .ALERT_CLR(aclr), .ALERT(alert));
   wmt_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .hit(hit));
   task automatic chk(input logic [11:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   task automatic do_reset;
      rst_b = 1'b0;
      for (int i = 0; i < 12; i++) rm[i] = i % 4 == 0 ? 8'hF0 : (i % 4 == 1 ? 8'hFF : 8'h00);
      st = '{0, 0, 0};
      cnt = '{0, 0, 0};
      exp_a = 0;
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      chk(alert, 3'h0);
   endtask : do_reset
   // Sweeps one address below and one above the bank; writes keep high above low
   task automatic scan(input bit w);
      logic [7:0] d;
      for (int i = -1; i < 13; i++) begin
         d = $random(seed);
         if (i % 4 == 1) d[7] = 1'b1;
         if (i % 4 == 2) d[3:2] = 2'b00;
         if (i % 4 == 3) d[7] = 1'b0;
         host.xfer(8'h34 + i[7:0], d, w, 1'b1, q, h);
         if (w && i >= 0 && i < 12) rm[i] = d;
         chk(q, (i >= 0 && i < 12) ? rm[i] : 8'h00);
         chk(h, i >= 0 && i < 12);
      end
   endtask : scan
   // Channel 0 means a clear with no sample; channel 4 is outside the bank
   task automatic smp(input int c, d, input logic [2:0] clr);
      int k, hi, lo, hy;
      k = c - 5;
      @(negedge clk);
      svalid = c != 0;
      sch = c[2:0];
      sdata = d[11:0];
      aclr = clr;
      if (k >= 0) begin
         hi = {rm[4*k+1], rm[4*k][7:4]};
         lo = {rm[4*k+3], rm[4*k+2][7:4]};
         hy = {rm[4*k][3:0], 3'b000};
         if (d > hi) st[k] = 1;
         else if (d < lo) st[k] = 2;
         else if (st[k] == 1 && d <= (hi < hy ? 0 : hi - hy)) st[k] = 0;
         else if (st[k] == 2 && d >= (lo + hy > 4095 ? 4095 : lo + hy)) st[k] = 0;
         cnt[k] = st[k] == 0 ? 0 : (cnt[k] < 16 ? cnt[k] + 1 : 16);
      end
      exp_a = exp_a & ~clr;
      if (k >= 0 && cnt[k] > rm[4*k+2][3:0]) exp_a = exp_a | (1 << k);
      @(negedge clk);
      svalid = 1'b0;
      aclr = 3'h0;
      chk(alert, exp_a[2:0]);
   endtask : smp
   initial begin
      do_reset();
      scan(1'b0);
      scan(1'b1);
      repeat (300) begin
         v = $unsigned($random(seed)) % 5;
         r = $random(seed);
         smp(v == 0 ? 0 : v + 3, r[11:0], r[14:12] == 3'h0 ? r[17:15] : 3'h0);
      end
      // Set and clear of one flag in the same cycle: the set must win
      host.xfer(8'h35, 8'h80, 1'b1, 1'b1, q, h);
      rm[1] = 8'h80;
      chk(q, rm[1]);
      host.xfer(8'h36, 8'h00, 1'b1, 1'b1, q, h);
      rm[2] = 8'h00;
      chk(q, rm[2]);
      smp(5, 12'hFFF, 3'h1);
      smp(5, 12'hFFF, 3'h1);
      do_reset();
      scan(1'b0);
      final_report();
   end
endmodule : window_monitor_threshold_regs_bench
`default_nettype wire
